// ### fspc_array_model.sv
// Purpose: behavioural flash array behind the controller's array port
// Assumes: one byte written per we, erase writes the erased value at arr.addr
// Notes:   preloaded with 3C so an erase or a stray write is visible
`timescale 1ns/1ps
`default_nettype none
module fspc_array_model
  import fspc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Array port
  input  wire fspc_arr_t   arr,
  input  wire logic [15:0] rd_addr,
  output logic [7:0]       rd_data
);
  logic [7:0] mem_ff [0:65535];

  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem_ff[i] = 8'h3C;
  end

  // Only the addressed byte changes, neighbours keep their contents
  always @(posedge clk)
    if (arr.we)
      mem_ff[arr.addr] <= arr.erase ? 8'hFF : arr.data;

  assign rd_data = mem_ff[rd_addr];
endmodule
`default_nettype wire

// ### fspc_cfg.svh
// Purpose: constants for the flash sector protection control block
// Assumes: 16-bit CPU address space, 8-bit data
// Notes:   array size is a top-level choice, sectors follow it
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH
`define FSPC_SEC0_BASE     16'hF000
`define FSPC_SEC1_BASE     16'hE000
`define FSPC_SEC_MSB       15
`define FSPC_SEC_LSB       12
`define FSPC_SEC0_TAG      4'hF
`define FSPC_SEC1_TAG      4'hE
`define FSPC_SIZE_4K       2'h0
`define FSPC_SIZE_8K       2'h1
`define FSPC_SIZE_BIG      2'h2
`define FSPC_CSR_RESET     8'h00
`define FSPC_ADDR_ZERO     16'h0000
`define FSPC_ADDR_LAST     16'hFFFF
`define FSPC_DATA_ERASED   8'hFF
`define FSPC_DATA_ZERO     8'h00
`define FSPC_PROG_CYCLES   4'h4
`define FSPC_CNT_ZERO      4'h0
`endif

// ### fspc_flash_ctrl.sv
// Summary of operation
// - The array erases whole or sector by sector and programs one byte per write.
// - A sector erase touches only addresses inside the chosen sector.
// - Tool and in-circuit modes may program and erase every sector and the option bytes.
// - In-application mode refuses program and erase on sector 0, mass erase and option writes; sectors 1 and 2 stay writable.
// - The array size selects how many user sectors exist: 4K one, 8K two, larger three.
// - Sectors 0 and 1 are 4 Kbytes at the top, sector 0 spanning F000h to FFFFh.
// - While read-out protection is on, every external read path returns nothing.
// - The option-byte protection bit alone turns read-out protection on and off.
// - Removing protection first erases the whole array, then clears the bit.
// - While protection is on, the low-voltage supervisor is disabled.
// - The control and status register resets to zero and belongs to tool software.
//
// Purpose: sequence program and erase on the flash array and enforce protection
// Assumes: requests are single-cycle pulses; array port writes or erases one byte per we
// Notes:   an erase walks the range one address per cycle, trading speed for a simple array port
`include "fspc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_ctrl
  import fspc_pkg::*;
#(
  parameter logic [1:0] SIZE_SEL = `FSPC_SIZE_BIG
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Mode and unlock
  input  wire fspc_mode_t  mode,
  input  wire logic        register_access_security_unlock,
  input  wire logic        opt_prot_load,
  input  wire logic        opt_prot_init,
  // Request
  input  wire fspc_req_t   req,
  output logic             req_ready,
  // External read path
  input  wire logic        ext_rd,
  input  wire logic [15:0] ext_rd_addr,
  input  wire logic [7:0]  arr_rd_data,
  output logic [15:0]      arr_rd_addr,
  output logic [7:0]       ext_rd_data,
  output logic             ext_rd_blocked,
  // Array write port
  output fspc_arr_t        arr,
  // Status
  output logic             readout_protect_bit,
  output logic             low_voltage_supervisor_en,
  output logic [7:0]       flash_control_status_reg,
  output logic             busy,
  output logic             op_done,
  output logic             op_refused
);
  fspc_st_t   cur_ff;
  fspc_st_t   nxt_st;
  logic [1:0] req_sector;
  logic       req_present;
  logic       req_writable;
  logic [1:0] cur_sector;
  logic [7:0] rd_data_ff;
  logic       rd_block_ff;

  fspc_sector_map u_map
  (
    .addr     (req.addr),
    .size_sel (SIZE_SEL),
    .mode     (mode),
    .sector   (req_sector),
    .present  (req_present),
    .writable (req_writable)
  );

  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a[`FSPC_SEC_MSB:`FSPC_SEC_LSB] == `FSPC_SEC0_TAG)
      sector_of = 2'h0;
    else if (a[`FSPC_SEC_MSB:`FSPC_SEC_LSB] == `FSPC_SEC1_TAG)
      sector_of = 2'h1;
    else
      sector_of = 2'h2;
  endfunction

  assign cur_sector = sector_of(cur_ff.addr);
  assign req_ready  = (cur_ff.state == FSPC_ST_IDLE);

  always_comb
  begin
    nxt_st         = cur_ff;
    nxt_st.done    = 1'b0;
    nxt_st.refused = 1'b0;
    arr            = '0;
    case (cur_ff.state)
      FSPC_ST_IDLE:
      begin
        if (opt_prot_load)
          nxt_st.prot = opt_prot_init;
        else if (req.valid && !register_access_security_unlock)
          nxt_st.refused = 1'b1;
        else if (req.valid)
        begin
          case (req.op)
            FSPC_OP_PROG:
            begin
              if (req_writable)
              begin
                nxt_st.state = FSPC_ST_BUSY;
                nxt_st.op    = req.op;
                nxt_st.addr  = req.addr;
                nxt_st.data  = req.data;
                nxt_st.cnt   = `FSPC_PROG_CYCLES;
              end
              else
                nxt_st.refused = 1'b1;
            end
            FSPC_OP_SECERS:
            begin
              if (req_writable)
              begin
                nxt_st.state = FSPC_ST_BUSY;
                nxt_st.op    = req.op;
                // Start at the sector base so the walk stays inside it
                nxt_st.addr  = (req_sector == 2'h0) ? `FSPC_SEC0_BASE :
                               (req_sector == 2'h1) ? `FSPC_SEC1_BASE : `FSPC_ADDR_ZERO;
              end
              else
                nxt_st.refused = 1'b1;
            end
            FSPC_OP_MASS:
            begin
              if (mode != FSPC_MODE_IAP)
              begin
                nxt_st.state = FSPC_ST_BUSY;
                nxt_st.op    = req.op;
                nxt_st.addr  = `FSPC_ADDR_ZERO;
              end
              else
                nxt_st.refused = 1'b1;
            end
            FSPC_OP_OPTWR:
            begin
              if (mode == FSPC_MODE_IAP)
                nxt_st.refused = 1'b1;
              else if (cur_ff.prot && !req.opt_prot)
              begin
                // Protection stays set until the whole array is gone
                nxt_st.state    = FSPC_ST_UNPR;
                nxt_st.addr     = `FSPC_ADDR_ZERO;
                nxt_st.opt_prot = req.opt_prot;
              end
              else
              begin
                nxt_st.prot = req.opt_prot;
                nxt_st.done = 1'b1;
              end
            end
            default:
              nxt_st.refused = 1'b1;
          endcase
        end
      end
      FSPC_ST_BUSY:
      begin
        case (cur_ff.op)
          FSPC_OP_PROG:
          begin
            if (cur_ff.cnt == `FSPC_CNT_ZERO)
            begin
              arr.we       = 1'b1;
              arr.addr     = cur_ff.addr;
              arr.data     = cur_ff.data;
              nxt_st.state = FSPC_ST_DONE;
            end
            else
              nxt_st.cnt = cur_ff.cnt - 4'h1;
          end
          default:
          begin
            arr.we    = 1'b1;
            arr.erase = 1'b1;
            arr.addr  = cur_ff.addr;
            arr.data  = `FSPC_DATA_ERASED;
            nxt_st.addr = cur_ff.addr + 16'h0001;
            // Sector erase ends when the next address leaves the sector
            if (cur_ff.addr == `FSPC_ADDR_LAST ||
                (cur_ff.op == FSPC_OP_SECERS && sector_of(cur_ff.addr + 16'h0001) != cur_sector))
              nxt_st.state = FSPC_ST_DONE;
          end
        endcase
      end
      FSPC_ST_UNPR:
      begin
        arr.we      = 1'b1;
        arr.erase   = 1'b1;
        arr.addr    = cur_ff.addr;
        arr.data    = `FSPC_DATA_ERASED;
        nxt_st.addr = cur_ff.addr + 16'h0001;
        if (cur_ff.addr == `FSPC_ADDR_LAST)
        begin
          nxt_st.prot  = cur_ff.opt_prot;
          nxt_st.state = FSPC_ST_DONE;
        end
      end
      FSPC_ST_DONE:
      begin
        nxt_st.done  = 1'b1;
        nxt_st.state = FSPC_ST_IDLE;
      end
      default:
        nxt_st.state = FSPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cur_ff       <= '0;
      cur_ff.state <= FSPC_ST_IDLE;
    end
    else
      cur_ff <= nxt_st;
  end

  // Read data is registered so the blocked value never glitches out
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rd_data_ff  <= `FSPC_DATA_ZERO;
      rd_block_ff <= 1'b0;
    end
    else
    begin
      rd_block_ff <= ext_rd && cur_ff.prot;
      if (ext_rd)
        rd_data_ff <= cur_ff.prot ? `FSPC_DATA_ZERO : arr_rd_data;
    end
  end

  assign arr_rd_addr               = ext_rd_addr;
  assign ext_rd_data               = rd_data_ff;
  assign ext_rd_blocked            = rd_block_ff;
  assign readout_protect_bit       = cur_ff.prot;
  assign low_voltage_supervisor_en = !cur_ff.prot;
  // Low bits mirror the sequencer outside idle; idle, as out of reset, reads all zero
  assign flash_control_status_reg  = {`FSPC_CSR_RESET, cur_ff.state} == {8'h00, FSPC_ST_IDLE} ?
                                     `FSPC_CSR_RESET : {4'h0, cur_ff.state};
  assign busy                      = (cur_ff.state != FSPC_ST_IDLE);
  assign op_done                   = cur_ff.done;
  assign op_refused                = cur_ff.refused;

  a_iap_sec0_guard: assert property (@(posedge clk) disable iff (!rst_b)
    (req.valid && req_ready && mode == FSPC_MODE_IAP && req.op == FSPC_OP_PROG && req_sector == 2'h0)
    |=> op_refused && !busy)
    else $error("sector 0 write accepted in application mode");
  a_unlock_needed: assert property (@(posedge clk) disable iff (!rst_b)
    (req.valid && req_ready && !opt_prot_load && !register_access_security_unlock) |=> op_refused && !busy)
    else $error("locked request was not ignored");
  a_read_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    (ext_rd && readout_protect_bit) |=> (ext_rd_data == `FSPC_DATA_ZERO) && ext_rd_blocked)
    else $error("protected read leaked data");
  a_lvd_off: assert property (@(posedge clk) disable iff (!rst_b)
    readout_protect_bit |-> !low_voltage_supervisor_en)
    else $error("supervisor active while protected");
  a_unprot_erase: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(readout_protect_bit) && !$past(opt_prot_load) |-> $past(arr.erase) && ($past(arr.addr) == `FSPC_ADDR_LAST))
    else $error("protection cleared before full erase");
  a_sec_erase_in: assert property (@(posedge clk) disable iff (!rst_b)
    (arr.erase && cur_ff.op == FSPC_OP_SECERS && cur_ff.state == FSPC_ST_BUSY) |-> sector_of(arr.addr) == cur_sector)
    else $error("sector erase strayed outside its sector");
  a_prog_one_byte: assert property (@(posedge clk) disable iff (!rst_b)
    (arr.we && !arr.erase) |=> !arr.we ##1 op_done)
    else $error("byte program did not complete singly");
  a_csr_reset: assert property (@(posedge clk)
    !rst_b |=> flash_control_status_reg == `FSPC_CSR_RESET)
    else $error("control register not zero after reset");
endmodule
`default_nettype wire

// ### fspc_flash_ctrl_tb_top.sv
// Purpose: self-checking bench for the flash sector protection controller
// Assumes: array model preloaded with 3C; second instance sized 4K
// Notes:   the full-array erase of 64K cycles on unprotect dominates the run time
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_ctrl_tb_top
  import fspc_pkg::*;
;
  typedef struct packed
  {
    logic [1:0]  mode;
    logic        unl;
    logic [2:0]  op;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        refd;
  } fspc_row_t;

  localparam fspc_row_t ROWS [10] = '{
    {2'h0, 1'b1, 3'h1, 16'hF010, 8'hA5, 1'b0},
    {2'h1, 1'b1, 3'h1, 16'hE020, 8'h5A, 1'b0},
    {2'h2, 1'b1, 3'h1, 16'hF030, 8'h77, 1'b1},
    {2'h2, 1'b1, 3'h1, 16'hE040, 8'h66, 1'b0},
    {2'h0, 1'b0, 3'h1, 16'h1234, 8'h11, 1'b1},
    {2'h2, 1'b1, 3'h2, 16'hF000, 8'h00, 1'b1},
    {2'h2, 1'b1, 3'h3, 16'h1000, 8'h00, 1'b1},
    {2'h0, 1'b1, 3'h7, 16'h0100, 8'h00, 1'b1},
    {2'h2, 1'b1, 3'h4, 16'h0200, 8'h00, 1'b1},
    {2'h0, 1'b1, 3'h1, 16'h0300, 8'h42, 1'b0}
  };

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  fspc_mode_t  mode = FSPC_MODE_TOOL;
  logic        unlock = 1'b0;
  logic        opt_prot_load = 1'b0;
  logic        opt_prot_init = 1'b0;
  fspc_req_t   req = '0;
  logic        ext_rd = 1'b0;
  logic [15:0] ext_rd_addr = 16'h0000;
  logic [7:0]  arr_rd_data;
  logic [15:0] arr_rd_addr;
  logic [7:0]  ext_rd_data;
  logic        ext_rd_blocked;
  fspc_arr_t   arr;
  logic        prot;
  logic        lvd_en;
  logic [7:0]  csr;
  logic        busy;
  logic        op_done;
  logic        op_refused;
  logic        rdy;
  logic        small_ref;
  logic        small_ref_ff = 1'b0;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc_ff = 0;
  logic        r;

  always #5 clk = ~clk;

  fspc_flash_ctrl dut_u (.clk(clk), .rst_b(rst_b), .mode(mode), .register_access_security_unlock(unlock),
    .opt_prot_load(opt_prot_load), .opt_prot_init(opt_prot_init), .req(req), .req_ready(rdy),
    .ext_rd(ext_rd), .ext_rd_addr(ext_rd_addr), .arr_rd_data(arr_rd_data), .arr_rd_addr(arr_rd_addr),
    .ext_rd_data(ext_rd_data), .ext_rd_blocked(ext_rd_blocked), .arr(arr), .readout_protect_bit(prot),
    .low_voltage_supervisor_en(lvd_en), .flash_control_status_reg(csr), .busy(busy), .op_done(op_done),
    .op_refused(op_refused));

  // Smallest array: only sector 0 exists
  fspc_flash_ctrl #(.SIZE_SEL(2'h0)) small_u (.clk(clk), .rst_b(rst_b), .mode(mode),
    .register_access_security_unlock(unlock), .opt_prot_load(opt_prot_load), .opt_prot_init(opt_prot_init),
    .req(req), .req_ready(), .ext_rd(ext_rd), .ext_rd_addr(ext_rd_addr), .arr_rd_data(8'h00),
    .arr_rd_addr(), .ext_rd_data(), .ext_rd_blocked(), .arr(), .readout_protect_bit(),
    .low_voltage_supervisor_en(), .flash_control_status_reg(), .busy(), .op_done(),
    .op_refused(small_ref));

  fspc_array_model mem_u (.clk(clk), .arr(arr), .rd_addr(arr_rd_addr), .rd_data(arr_rd_data));

  always @(posedge clk)
  begin
    cyc_ff <= cyc_ff + 1;
    if (small_ref === 1'b1)
      small_ref_ff <= 1'b1;
    if (cyc_ff == 80000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic do_req(input logic [1:0] m, input logic u, input logic [2:0] o, input logic [15:0] a,
                        input logic [7:0] d, input logic p, output logic refd);
    int n;
    n = 0;
    @(posedge clk);
    mode <= fspc_mode_t'(m);
    unlock <= u;
    req <= '{1'b1, fspc_op_t'(o), a, d, p};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    while (!(op_done === 1'b1 || op_refused === 1'b1) && n < 70000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    refd = op_refused;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input logic eb);
    @(posedge clk);
    ext_rd <= 1'b1;
    ext_rd_addr <= a;
    @(posedge clk);
    ext_rd <= 1'b0;
    #1;
    chk({7'h00, ext_rd_blocked, ext_rd_data}, {7'h00, eb, e});
  endtask

  task final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk({busy, prot, lvd_en, csr}, {3'h1, 8'h00});
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      do_req(ROWS[i].mode, ROWS[i].unl, ROWS[i].op, ROWS[i].addr, ROWS[i].data, 1'b1, r);
      chk(r, ROWS[i].refd);
      rdchk(ROWS[i].addr, ROWS[i].refd ? 8'h3C : ROWS[i].data, 1'b0);
    end
    chk(prot, 1'b0);
    chk(small_ref_ff, 1'b1);
    $display("test table done");
    // Sector 1 erase must stop at both 4K boundaries
    do_req(2'h1, 1'b1, 3'h2, 16'hE000, 8'h00, 1'b0, r);
    chk(r, 1'b0);
    rdchk(16'hE040, 8'hFF, 1'b0);
    rdchk(16'hF010, 8'hA5, 1'b0);
    rdchk(16'hDFFF, 8'h3C, 1'b0);
    $display("test sector erase done");
    @(posedge clk);
    opt_prot_load <= 1'b1;
    opt_prot_init <= 1'b1;
    @(posedge clk);
    opt_prot_load <= 1'b0;
    #1;
    chk({prot, lvd_en}, 2'h2);
    rdchk(16'hF010, 8'h00, 1'b1);
    $display("test protect done");
    // Clearing the bit runs the full-array erase first
    do_req(2'h0, 1'b1, 3'h4, 16'h0000, 8'h00, 1'b0, r);
    chk({r, prot, lvd_en}, 3'h1);
    rdchk(16'hF010, 8'hFF, 1'b0);
    rdchk(16'h0300, 8'hFF, 1'b0);
    $display("test unprotect done");
    // Program timing: busy right after accept, done state, then the done pulse
    @(posedge clk);
    mode <= FSPC_MODE_TOOL;
    unlock <= 1'b1;
    req <= '{1'b1, FSPC_OP_PROG, 16'h0400, 8'h99, 1'b0};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk({rdy, busy, csr}, {2'h1, 8'h02});
    repeat (5) @(posedge clk);
    #1;
    chk({rdy, busy, op_done, csr}, {3'h2, 8'h08});
    @(posedge clk);
    #1;
    chk({rdy, busy, op_done, csr}, {3'h5, 8'h00});
    rdchk(16'h0400, 8'h99, 1'b0);
    $display("test program timing done");
    final_report();
  end
endmodule
`default_nettype wire

// ### fspc_pkg.sv
// Purpose: shared types for the flash sector protection control block
// Assumes: fspc_cfg.svh holds the addresses, sizes and counts; the enum codes are set here
// Notes:   types only
`default_nettype none
package fspc_pkg;
  typedef enum logic [1:0]
  {
    FSPC_MODE_TOOL = 2'h0,
    FSPC_MODE_ICP  = 2'h1,
    FSPC_MODE_IAP  = 2'h2
  } fspc_mode_t;

  typedef enum logic [2:0]
  {
    FSPC_OP_NONE   = 3'h0,
    FSPC_OP_PROG   = 3'h1,
    FSPC_OP_SECERS = 3'h2,
    FSPC_OP_MASS   = 3'h3,
    FSPC_OP_OPTWR  = 3'h4
  } fspc_op_t;

  typedef enum logic [3:0]
  {
    FSPC_ST_IDLE  = 4'b0001,
    FSPC_ST_BUSY  = 4'b0010,
    FSPC_ST_UNPR  = 4'b0100,
    FSPC_ST_DONE  = 4'b1000
  } fspc_state_t;

  typedef struct packed
  {
    logic       valid;
    fspc_op_t   op;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        opt_prot;
  } fspc_req_t;

  typedef struct packed
  {
    logic        we;
    logic        erase;
    logic [15:0] addr;
    logic [7:0]  data;
  } fspc_arr_t;

  typedef struct packed
  {
    fspc_state_t state;
    fspc_op_t    op;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [3:0]  cnt;
    logic        prot;
    logic        opt_prot;
    logic        done;
    logic        refused;
  } fspc_st_t;
endpackage
`default_nettype wire

// ### fspc_sector_map.sv
// Purpose: decode an address into a user sector and its permission
// Assumes: sectors 0 and 1 are 4 Kbytes at the top, sector 2 is the rest
// Notes:   purely combinational
`include "fspc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module fspc_sector_map
  import fspc_pkg::*;
(
  // Query
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  size_sel,
  input  wire fspc_mode_t  mode,
  // Answer
  output logic [1:0]       sector,
  output logic             present,
  output logic             writable
);
  always_comb
  begin
    if (addr[`FSPC_SEC_MSB:`FSPC_SEC_LSB] == `FSPC_SEC0_TAG)
      sector = 2'h0;
    else if (addr[`FSPC_SEC_MSB:`FSPC_SEC_LSB] == `FSPC_SEC1_TAG)
      sector = 2'h1;
    else
      sector = 2'h2;
    case (size_sel)
      `FSPC_SIZE_4K:  present = (sector == 2'h0);
      `FSPC_SIZE_8K:  present = (sector != 2'h2);
      default:        present = 1'b1;
    endcase
    // Sector 0 keeps the bootloader, so the running code may never touch it
    writable = present && !((mode == FSPC_MODE_IAP) && (sector == 2'h0));
  end
endmodule
`default_nettype wire
